// ### verilog/csd_chip_select_decoder.sv
// Overview of operation
// [RL1] Assert a select only when space, address, direction, size and level all match.
// [RL2] Select outputs are active low.
// [RL3] Accesses to on-chip resources never assert a select nor show externally.
// [RL4] Non-boot selects stay off until their byte-lane field is nonzero.
// [RL5] Software writes a base register before the matching option register.
// [RL6] Boot select works straight out of reset without software setup.
// [RL7] Pin assignment holds twelve 2-bit function fields.
// [RL8] Codes: 00 discrete, 01 alternate, 10 8-bit select, 11 16-bit select.
// [RL9] Software never writes discrete code to pins lacking discrete output.
// [RL10] Pins 3-9 drive discrete bits 0-6; pin 10 gives slow clock.
// [RL11] Discrete-output pin drives its data register bit.
// [RL12] Reset strap sets each non-boot pin to 16-bit select or alternate.
// [RL13] Strap bit 0 at reset picks boot port width: high 16, low 8.
// [RL14] Decoding stays active when pin is discrete or alternate.
// [RL15] Block-size field chooses compared address bits, 2K to 1M.
// [RL16] Only upper bits chosen by block size are compared; base is lowest.
// [RL17] Software aligns base to block size.
// [RL18] Selects match independently; blocks may overlap.
// [RL19] Boot base resets to zero with 512K block.
// [RL20] Assertion follows bus strobes or, optionally, the slow bus clock.
// [RL21] Acknowledge field: 0-13 waits, fast termination, or external.
// [RL22] Byte-lane codes off/lower/upper/both; boot lane field resets to both.
// [RL23] Async asserts with address or data strobe; sync follows slow clock.
`default_nettype none
module csd_chip_select_decoder
  import csd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Bus access being decoded
  input wire logic [23:0] acc_addr,
  input wire logic [2:0] acc_fc,
  input wire logic acc_read,
  input wire logic [1:0] acc_siz,
  input wire logic acc_as,
  input wire logic acc_ds,
  input wire logic acc_internal,
  // Reset straps from data pins
  input wire logic [7:0] data_strap,
  // Pins and termination
  output logic [11:0] select_n,
  output logic [11:0] pin_level,
  output logic [11:0] pin_alt,
  output logic slow_bus_clock,
  output logic size_acknowledge,
  output logic autovector_request,
  output logic ext_bus_show
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic base_hit(input logic [7:0] adr, input int k);
    if (k == 0) begin
      return adr == OFS_BOOT_BASE;
    end
    return adr == OFS_SEL_BASE + 8'((k - 1) * 4);
  endfunction

  function automatic logic opt_hit(input logic [7:0] adr, input int k);
    if (k == 0) begin
      return adr == OFS_BOOT_OPT;
    end
    return adr == OFS_SEL_OPT + 8'((k - 1) * 4);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel);
    return {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction

  // Strap pin feeding each pin field; fewer straps than pins
  function automatic int strap_of(input int k);
    if (k == 0) begin
      return 0;
    end
    if (k <= 3) begin
      return 1;
    end
    if (k <= 6) begin
      return 2;
    end
    return k - 4;
  endfunction

  function automatic logic space_ok(input logic [1:0] space, input logic [2:0] ack_level_field,
                                    input logic [2:0] fc, input logic [23:0] addr);
    logic user;
    logic supv;
    user = (fc == 3'h1) || (fc == 3'h2);
    supv = (fc == 3'h5) || (fc == 3'h6);
    unique case (space)
      SPACE_CPU: return (fc == FC_CPU) && ((ack_level_field == 3'h0) ||
                        ((addr[19:16] == IACK_TYPE) && (addr[3:1] == ack_level_field)));
      SPACE_USER: return user;
      SPACE_SUPV: return supv;
      default: return user || supv;
    endcase
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] base_reg [NUM_SEL];
  logic [15:0] opt_reg [NUM_SEL];
  logic [1:0] pin_func [NUM_SEL];
  logic [6:0] discrete_out_register;
  logic [7:0] strap_s1;
  logic [7:0] strap_s2;
  logic strap_taken;
  logic wr_en;
  logic [11:0] next_sel;
  logic [11:0] match;

  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;

  // Straps run free through reset so they are settled at release
  always_ff @(posedge clk_sys) begin
    strap_s1 <= data_strap;
    strap_s2 <= strap_s1;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      strap_taken <= 1'b0;
    end else begin
      strap_taken <= 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_SEL; g++) begin : g_regs
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          base_reg[g] <= (g == 0) ? BOOT_BASE_RST : SEL_BASE_RST; // RL19
          opt_reg[g] <= (g == 0) ? BOOT_OPT_RST : SEL_OPT_RST; // RL4 RL22
        end else if (wr_en) begin
          if (base_hit(wb_adr_i, g)) begin
            base_reg[g] <= merge16(base_reg[g], wb_dat_i, wb_sel_i);
          end
          if (opt_hit(wb_adr_i, g)) begin
            opt_reg[g] <= merge16(opt_reg[g], wb_dat_i, wb_sel_i);
          end
        end
      end

      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          pin_func[g] <= PIN_CS16;
        end else if (!strap_taken) begin
          if (g == 0) begin
            pin_func[g] <= strap_s2[0] ? PIN_CS16 : PIN_CS8; // RL13
          end else begin
            pin_func[g] <= strap_s2[strap_of(g)] ? PIN_CS16 : PIN_ALT; // RL12
          end
        end else if (wr_en) begin
          if (g < FIELDS_IN_ASSIGN_0 && wb_adr_i == OFS_PIN_ASSIGN_0 &&
              wb_sel_i[g / 4]) begin
            pin_func[g] <= wb_dat_i[2 * g +: 2]; // RL7
          end
          if (g >= FIELDS_IN_ASSIGN_0 && wb_adr_i == OFS_PIN_ASSIGN_1 && wb_sel_i[0]) begin
            pin_func[g] <= wb_dat_i[2 * (g - FIELDS_IN_ASSIGN_0) +: 2]; // RL7
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      discrete_out_register <= DISC_RST;
    end else if (wr_en && wb_adr_i == OFS_DISCRETE && wb_sel_i[0]) begin
      discrete_out_register <= wb_dat_i[6:0];
    end
  end

  // ****************************************
  // Wishbone read and acknowledge
  // ****************************************
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0;
    if (wb_adr_i == OFS_PIN_ASSIGN_0) begin
      for (int k = 0; k < FIELDS_IN_ASSIGN_0; k++) begin
        next_rdata[2 * k +: 2] = pin_func[k];
      end
    end else if (wb_adr_i == OFS_PIN_ASSIGN_1) begin
      for (int k = FIELDS_IN_ASSIGN_0; k < NUM_SEL; k++) begin
        next_rdata[2 * (k - FIELDS_IN_ASSIGN_0) +: 2] = pin_func[k];
      end
    end else if (wb_adr_i == OFS_DISCRETE) begin
      next_rdata[6:0] = discrete_out_register;
    end else if (wb_adr_i == OFS_STATUS) begin
      next_rdata[11:0] = ~select_n;
    end else begin
      for (int k = 0; k < NUM_SEL; k++) begin
        if (base_hit(wb_adr_i, k)) begin
          next_rdata[15:0] = base_reg[k];
        end
        if (opt_hit(wb_adr_i, k)) begin
          next_rdata[15:0] = opt_reg[k];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= next_rdata;
    end
  end

  // ****************************************
  // Slow bus clock
  // ****************************************
  logic [3:0] slow_cnt;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slow_cnt <= 4'h0;
      slow_bus_clock <= 1'b0;
    end else if (slow_cnt == 4'(SLOW_HALF_CYC - 1)) begin
      slow_cnt <= 4'h0;
      slow_bus_clock <= ~slow_bus_clock;
    end else begin
      slow_cnt <= slow_cnt + 4'h1;
    end
  end

  // ****************************************
  // Address and control match
  // ****************************************
  // Lanes used on a 16-bit port: even address takes the upper byte
  logic lane_upper;
  logic lane_lower;
  assign lane_upper = ~acc_addr[0];
  assign lane_lower = acc_addr[0] | (acc_siz != 2'h1);

  generate
    for (g = 0; g < NUM_SEL; g++) begin : g_match
      logic [1:0] lanes;
      logic [1:0] rw;
      logic addr_ok;
      logic byte_ok;
      logic gate;
      assign lanes = opt_reg[g][OPT_BYTE_LSB +: 2];
      assign rw = opt_reg[g][OPT_RW_LSB +: 2];
      // Mask from block size, so unaligned base bits are simply ignored
      assign addr_ok = ((acc_addr[23:11] ^ base_reg[g][15:BASE_ADDR_LSB]) &
                        BLK_MASK[base_reg[g][2:0]]) == 13'h0; // RL15 RL16
      assign byte_ok = (pin_func[g] == PIN_CS16) ?
                       |(lanes & {lane_upper, lane_lower}) : (lanes != 2'h0); // RL4 RL22
      // Each select decodes alone, whatever its pin does
      assign match[g] = ~acc_internal & addr_ok & byte_ok &
                        (acc_read ? rw[0] : rw[1]) &
                        space_ok(opt_reg[g][OPT_SPACE_LSB +: 2],
                                 opt_reg[g][OPT_IPL_LSB +: 3], acc_fc, acc_addr); // RL1 RL3 RL14 RL18
      assign gate = opt_reg[g][OPT_MODE_BIT] ? (acc_as & slow_bus_clock) :
                    (opt_reg[g][OPT_STROBE_CHOICE_BIT_BIT] ? acc_ds : acc_as); // RL20 RL23
      assign next_sel[g] = match[g] & gate;
    end
  endgenerate

  // ****************************************
  // Pins
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      select_n <= 12'hfff;
      ext_bus_show <= 1'b0;
      autovector_request <= 1'b0;
    end else begin
      select_n <= ~next_sel; // RL2 RL6
      ext_bus_show <= ~acc_internal; // RL3
      autovector_request <= 1'b0;
      for (int k = 0; k < NUM_SEL; k++) begin
        if (match[k] && acc_as && opt_reg[k][OPT_AUTOVECTOR_REQUEST_BIT] && acc_fc == FC_CPU) begin
          autovector_request <= 1'b1; // RL14
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_level <= 12'hfff;
      pin_alt <= 12'h000;
    end else begin
      for (int k = 0; k < NUM_SEL; k++) begin
        pin_alt[k] <= pin_func[k] == PIN_ALT; // RL8
        unique case (pin_func[k])
          PIN_CS8, PIN_CS16: pin_level[k] <= ~next_sel[k]; // RL8
          PIN_DISCRETE: begin
            // Pins without a discrete output just idle high
            if (k >= 4 && k <= 10) begin
              pin_level[k] <= discrete_out_register[k - 4]; // RL10 RL11
            end else if (k == 11) begin
              pin_level[k] <= slow_bus_clock; // RL10
            end else begin
              pin_level[k] <= 1'b1; // RL9
            end
          end
          default: pin_level[k] <= 1'b1;
        endcase
      end
    end
  end

  // ****************************************
  // Internal size acknowledge
  // ****************************************
  csd_ack_state_t ack_state;
  logic [3:0] wait_cnt;
  logic as_q;
  logic start;
  logic ack_hit;
  logic [3:0] ack_code;

  // Lowest-numbered matching async select not using external acknowledge sets the wait count
  always_comb begin
    ack_hit = 1'b0;
    ack_code = SIZE_ACKNOWLEDGE_EXT;
    for (int k = NUM_SEL - 1; k >= 0; k--) begin
      if (match[k] && !opt_reg[k][OPT_MODE_BIT] &&
          opt_reg[k][OPT_SIZE_ACKNOWLEDGE_LSB +: 4] != SIZE_ACKNOWLEDGE_EXT) begin
        ack_hit = 1'b1;
        ack_code = opt_reg[k][OPT_SIZE_ACKNOWLEDGE_LSB +: 4];
      end
    end
  end

  assign start = acc_as & ~as_q & ack_hit & (ack_state == ST_IDLE);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      as_q <= 1'b0;
      ack_state <= ST_IDLE;
      wait_cnt <= 4'h0;
      size_acknowledge <= 1'b0;
    end else begin
      as_q <= acc_as;
      size_acknowledge <= 1'b0;
      unique case (ack_state)
        ST_IDLE: begin
          if (start) begin
            ack_state <= ST_WAIT;
            wait_cnt <= (ack_code == SIZE_ACKNOWLEDGE_FAST) ? 4'h0 : ack_code + 4'h1; // RL21
          end
        end
        ST_WAIT: begin
          if (wait_cnt == 4'h0) begin
            size_acknowledge <= 1'b1; // RL21
            ack_state <= ST_DONE;
          end else begin
            wait_cnt <= wait_cnt - 4'h1;
          end
        end
        ST_DONE: begin
          if (!acc_as) begin
            ack_state <= ST_IDLE;
          end
        end
        default: ack_state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_internal_no_sel: assert property (@(posedge clk_sys) disable iff (rst) // RL3
    acc_internal |=> (select_n == 12'hfff) && !ext_bus_show)
    else $error("select asserted on internal access");
  a_sel_needs_match: assert property (@(posedge clk_sys) disable iff (rst) // RL1
    !select_n[1] |-> $past(match[1]) && $past(acc_as))
    else $error("select 0 asserted without match");
  a_lane_off_quiet: assert property (@(posedge clk_sys) disable iff (rst) // RL4
    (opt_reg[2][OPT_BYTE_LSB +: 2] == 2'h0) |=> select_n[2])
    else $error("select 1 asserted with lanes disabled");
  a_boot_reset_vals: assert property (@(posedge clk_sys) disable iff (rst) // RL19
    !strap_taken |-> base_reg[0] == BOOT_BASE_RST && opt_reg[0] == BOOT_OPT_RST)
    else $error("boot registers not at reset values");
  a_boot_width: assert property (@(posedge clk_sys) disable iff (rst) // RL13
    !strap_taken |=> pin_func[0] == ($past(strap_s2[0]) ? PIN_CS16 : PIN_CS8))
    else $error("boot width not from strap");
  a_strap_codes: assert property (@(posedge clk_sys) disable iff (rst) // RL12
    !strap_taken |=> pin_func[5] == ($past(strap_s2[2]) ? PIN_CS16 : PIN_ALT))
    else $error("strapped pin function wrong");
  a_discrete_drive: assert property (@(posedge clk_sys) disable iff (rst) // RL11
    pin_func[4] == PIN_DISCRETE |=> pin_level[4] == $past(discrete_out_register[0]))
    else $error("discrete pin not driving data bit");
  a_slow_clk_pin: assert property (@(posedge clk_sys) disable iff (rst) // RL10
    pin_func[11] == PIN_DISCRETE |=> pin_level[11] == $past(slow_bus_clock))
    else $error("pin 10 not giving slow clock");
  a_ack_zero_wait: assert property (@(posedge clk_sys) disable iff (rst) // RL21
    start && ack_code == 4'h0 |-> !size_acknowledge [*3] ##1 size_acknowledge)
    else $error("zero-wait acknowledge mistimed");
  a_ack_fast: assert property (@(posedge clk_sys) disable iff (rst) // RL21
    start && ack_code == SIZE_ACKNOWLEDGE_FAST |-> ##2 size_acknowledge ##1 !size_acknowledge)
    else $error("fast termination mistimed");
  c_boot_select: cover property (@(posedge clk_sys) disable iff (rst) !select_n[0]);
  c_ack_waits: cover property (@(posedge clk_sys) disable iff (rst)
    start && ack_code == 4'h3 ##6 size_acknowledge);
  c_autovector: cover property (@(posedge clk_sys) disable iff (rst) autovector_request);
  c_overlap: cover property (@(posedge clk_sys) disable iff (rst) !select_n[0] && !select_n[1]);

endmodule // csd_chip_select_decoder
`default_nettype wire

// ### verilog/csd_pkg.sv
`default_nettype none
package csd_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_SEL = 12;
  localparam int NUM_DISC = 7;
  localparam int NUM_STRAP = 8;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_PIN_ASSIGN_0 = 8'h00;
  localparam logic [7:0] OFS_PIN_ASSIGN_1 = 8'h04;
  localparam logic [7:0] OFS_DISCRETE = 8'h08;
  localparam logic [7:0] OFS_BOOT_BASE = 8'h0c;
  localparam logic [7:0] OFS_BOOT_OPT = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_SEL_BASE = 8'h40;
  localparam logic [7:0] OFS_SEL_OPT = 8'h80;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BASE_ADDR_LSB = 3;
  localparam int OPT_MODE_BIT = 15;
  localparam int OPT_BYTE_LSB = 13;
  localparam int OPT_RW_LSB = 11;
  localparam int OPT_STROBE_CHOICE_BIT_BIT = 10;
  localparam int OPT_SIZE_ACKNOWLEDGE_LSB = 6;
  localparam int OPT_SPACE_LSB = 4;
  localparam int OPT_IPL_LSB = 1;
  localparam int OPT_AUTOVECTOR_REQUEST_BIT = 0;
  localparam int FIELDS_IN_ASSIGN_0 = 8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] BOOT_BASE_RST = 16'h0006;
  localparam logic [15:0] SEL_BASE_RST = 16'h0000;
  localparam logic [15:0] BOOT_OPT_RST = 16'h7b70;
  localparam logic [15:0] SEL_OPT_RST = 16'h0000;
  localparam logic [6:0] DISC_RST = 7'h00;

  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [1:0] PIN_DISCRETE = 2'h0;
  localparam logic [1:0] PIN_ALT = 2'h1;
  localparam logic [1:0] PIN_CS8 = 2'h2;
  localparam logic [1:0] PIN_CS16 = 2'h3;
  localparam logic [3:0] SIZE_ACKNOWLEDGE_FAST = 4'he;
  localparam logic [3:0] SIZE_ACKNOWLEDGE_EXT = 4'hf;
  localparam logic [1:0] SPACE_CPU = 2'h0;
  localparam logic [1:0] SPACE_USER = 2'h1;
  localparam logic [1:0] SPACE_SUPV = 2'h2;
  localparam logic [2:0] FC_CPU = 3'h7;
  localparam logic [3:0] IACK_TYPE = 4'hf;
  localparam logic [12:0] BLK_MASK [8] = '{13'h1fff, 13'h1ffc, 13'h1ff8, 13'h1fe0,
                                          13'h1fc0, 13'h1f80, 13'h1f00, 13'h1e00};

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int SLOW_CLK_PERIOD_NS = 200;
  localparam int SLOW_HALF_CYC = SLOW_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_DONE = 3'h4
  } csd_ack_state_t;

endpackage
`default_nettype wire

// ### dv/csd_ext_device.sv
`default_nettype none
module csd_ext_device
  import csd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Select lines from the decoder
  input wire logic [11:0] select_n,
  // Which devices were ever selected
  output logic [11:0] hit_seen
);
  timeunit 1ns;
  timeprecision 1ns;

  // A device only responds while its select is low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hit_seen <= 12'h000;
    end else begin
      hit_seen <= hit_seen | ~select_n;
    end
  end
endmodule // csd_ext_device
`default_nettype wire

// ### dv/testbench.sv
`default_nettype none
module testbench
  import csd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Signals
  // ****
  logic clk_sys, rst, wb_cyc, wb_stb, wb_we, acc_read, acc_as, acc_ds, acc_internal;
  logic [7:0] wb_adr, data_strap;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat, wb_dat_o, rs, q, r;
  logic [23:0] acc_addr, base;
  logic [2:0] acc_fc;
  logic [1:0] acc_siz;
  logic [11:0] select_n, pin_level, pin_alt, hit_seen, s;
  logic wb_ack_o, slow_bus_clock, size_acknowledge, autovector_request, ext_bus_show;
  int error_cnt, samples_checked, n;
  int lsb [8] = '{11, 13, 14, 16, 17, 18, 19, 20};
  logic [3:0] codes [5] = '{4'h0, 4'h5, 4'hd, SIZE_ACKNOWLEDGE_FAST, SIZE_ACKNOWLEDGE_EXT};

  csd_chip_select_decoder i_csd_chip_select_decoder (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .acc_addr(acc_addr), .acc_fc(acc_fc), .acc_read(acc_read),
    .acc_siz(acc_siz), .acc_as(acc_as), .acc_ds(acc_ds), .acc_internal(acc_internal),
    .data_strap(data_strap), .select_n(select_n), .pin_level(pin_level),
    .pin_alt(pin_alt), .slow_bus_clock(slow_bus_clock),
    .size_acknowledge(size_acknowledge), .autovector_request(autovector_request),
    .ext_bus_show(ext_bus_show));
  csd_ext_device i_csd_ext_device (
    .clk_sys(clk_sys), .rst(rst), .select_n(select_n), .hit_seen(hit_seen));

  always #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

  // ****
  // Helpers
  // ****
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int k;
    @(posedge clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= {16'h0000, d};
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 16);
    if (k >= 16) begin
      error_cnt++;
      report_and_stop();
    end
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 16'h0000);
    chk(q, e);
  endtask

  // One strobed access; s holds the selects seen one cycle after the strobe
  task automatic acc(input logic [23:0] a, input logic [2:0] fc, input logic rd,
                     input logic i);
    r = xs();
    @(posedge clk_sys);
    acc_addr <= a;
    acc_fc <= fc;
    acc_read <= rd;
    acc_internal <= i;
    acc_siz <= r[1:0];
    acc_as <= 1'b1;
    repeat (2) @(posedge clk_sys);
    s = select_n;
    acc_as <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  // ****
  // Sequence
  // ****
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    {wb_cyc, wb_stb, wb_we, acc_read, acc_as, acc_ds, acc_internal} = 7'h00;
    {wb_adr, wb_dat, acc_addr, acc_fc, acc_siz} = '0;
    wb_sel = 4'hf;
    data_strap = 8'hfd;
    rs = 32'd44;
    repeat (4) @(posedge clk_sys);
    chk(select_n, 12'hfff);
    rst <= 1'b0;
    rdc(OFS_PIN_ASSIGN_0, 32'hff57);
    rdc(OFS_PIN_ASSIGN_1, 32'h00ff);
    chk(pin_alt, 12'h00e);
    rdc(OFS_BOOT_BASE, 32'h0006);
    rdc(OFS_BOOT_OPT, 32'h7b70);
    rdc(OFS_SEL_OPT, 32'h0000);
    rdc(8'h3c, 32'h0000);
    repeat (4) begin
      r = xs();
      acc({5'h00, r[18:0]}, {r[21], r[22], ~r[22]}, r[20], 1'b0);
      chk(s[0], 1'b0);
    end
    acc(24'h080000, 3'h6, 1'b1, 1'b0);
    chk(s[0], 1'b1);
    acc(24'h000100, FC_CPU, 1'b1, 1'b0);
    chk(s[0], 1'b1);
    acc(24'h000100, 3'h6, 1'b1, 1'b1);
    chk({s[0], ext_bus_show}, 2'b10);
    acc(24'h000100, 3'h5, 1'b1, 1'b0);
    chk(ext_bus_show, 1'b1);
    // Pins lacking a discrete output keep codes 01 or 11
    for (int p = 0; p < 4; p++) begin
      r = xs();
      wb(1'b1, OFS_DISCRETE, r[15:0]);
      wb(1'b1, OFS_PIN_ASSIGN_0, {{4{p[1:0]}}, 8'h57});
      wb(1'b1, OFS_PIN_ASSIGN_1, {8'h00, {4{p[1:0]}}});
      rdc(OFS_PIN_ASSIGN_0, {16'h0000, {4{p[1:0]}}, 8'h57});
      chk(pin_level[10:4], p == 0 ? r[6:0] : 7'h7f);
      chk(pin_alt[10:4], p == 1 ? 7'h7f : 7'h00);
    end
    rdc(OFS_DISCRETE, {25'h0, r[6:0]});
    wb(1'b1, OFS_PIN_ASSIGN_0, 16'hffff);
    wb(1'b1, OFS_SEL_BASE + 8'h04, 16'h0000);
    acc(24'h000010, 3'h6, 1'b0, 1'b0);
    chk(s[2], 1'b1);
    for (int c = 0; c < 8; c++) begin
      r = xs();
      base = r[23:0] >> lsb[c] << lsb[c];
      wb(1'b1, OFS_SEL_BASE + 8'h04, {base[23:11], c[2:0]});
      wb(1'b1, OFS_SEL_OPT + 8'h04, 16'h7bf0);
      acc(base + (24'h1 << lsb[c]) - 24'h1, {r[24], r[25], ~r[25]}, r[26], 1'b0);
      chk(s[2], 1'b0);
      acc(base + (24'h1 << lsb[c]), 3'h6, 1'b1, 1'b0);
      chk(s[2], 1'b1);
    end
    wb(1'b1, OFS_SEL_OPT + 8'h04, 16'h6bf0);
    acc(base, 3'h6, 1'b0, 1'b0);
    chk(s[2], 1'b1);
    acc(base, 3'h6, 1'b1, 1'b0);
    chk(s[2], 1'b0);
    // Select 1 pin on its alternate function, decoding must stay alive
    wb(1'b1, OFS_PIN_ASSIGN_0, 16'hffdf);
    wb(1'b1, OFS_SEL_BASE + 8'h04, 16'h3000);
    foreach (codes[j]) begin
      wb(1'b1, OFS_SEL_OPT + 8'h04, {5'h0f, 1'b0, codes[j], 6'h30});
      // Boot select may still be counting its own waits
      repeat (20) @(posedge clk_sys);
      acc_addr <= 24'h300010;
      acc_fc <= 3'h6;
      acc_internal <= 1'b0;
      acc_as <= 1'b1;
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (size_acknowledge !== 1'b1 && n < 20);
      chk(n, codes[j] == SIZE_ACKNOWLEDGE_EXT ? 20 : codes[j] == SIZE_ACKNOWLEDGE_FAST ? 3 : 4 + codes[j]);
      acc_as <= 1'b0;
    end
    for (n = 0; n < 40 && slow_bus_clock !== 1'b0; n++) @(posedge clk_sys);
    for (n = 0; n < 40 && slow_bus_clock !== 1'b1; n++) @(posedge clk_sys);
    for (n = 0; n < 40 && slow_bus_clock === 1'b1; n++) @(posedge clk_sys);
    chk(n, SLOW_HALF_CYC);
    chk(hit_seen, 12'h005);
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
